// ---- verilog/testbus_pkg.sv ----
// constants shared by the test bus pad router files
package testbus_pkg;

   // ----------------------------------------------------------------
   // register indices, byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [7:0] idx_enable = 8'h17;
   localparam logic [7:0] idx_mode = 8'hf0;
   localparam logic [7:0] idx_group = 8'hf1;
   localparam logic [7:0] idx_zero_to_one = 8'hf2;
   localparam logic [7:0] idx_map_count = 8'hf3;
   localparam logic [7:0] idx_map_entries = 8'hf4;
   localparam logic [7:0] idx_dac_one = 8'hf5;
   localparam logic [7:0] idx_dac_two = 8'hf6;
   localparam logic [7:0] idx_pad_status = 8'hf8;
   localparam int unsigned addr_w = 12;

   // ----------------------------------------------------------------
   // field values
   // ----------------------------------------------------------------
   localparam logic [7:0] mode_analog = 8'h01;
   localparam logic [7:0] mode_digital = 8'h02;
   localparam logic [7:0] map_zero_onto_one = 8'h00;
   localparam logic [3:0] sig_clock = 4'h8;
   localparam int unsigned enable_bit = 0;
   localparam int unsigned num_pads = 4;
   localparam int unsigned num_entries = 4;
   localparam int unsigned entry_w = 8;
   localparam int unsigned pad_irq = 0;
   localparam int unsigned pad_aux_two = 1;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] rst_byte = 8'h00;
   localparam logic [31:0] rst_word = 32'h0000_0000;

   // byte address of a register index
   function automatic logic [addr_w-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = {2'b00, idx, 2'b00};
   endfunction

endpackage

// ---- verilog/map_entry_decoder.sv ----
// decodes one pad map entry into a pad select and a level
module map_entry_decoder #(
   parameter int unsigned tb_w = 8
) (
   input wire logic [7:0] entry,
   input wire logic active,
   input wire logic [tb_w-1:0] test_bus,
   input wire logic clk_13m,
   output logic [3:0] pad_hit,
   output logic level
);

   logic [3:0] pad_code;
   logic [3:0] sig_code;

   assign pad_code = entry[7:4];
   assign sig_code = entry[3:0];

   always_comb
   begin
      pad_hit = 4'h0;
      level = 1'b0;
      if (sig_code < testbus_pkg::sig_clock)
      begin
         level = test_bus[sig_code[2:0]];
      end
      else
      begin
         level = clk_13m;
      end
      // reserved pad or signal codes select nothing
      if (active && pad_code < 4'(testbus_pkg::num_pads) &&
          sig_code <= testbus_pkg::sig_clock)
      begin
         pad_hit[pad_code[1:0]] = 1'b1;
      end
   end

endmodule

// ---- verilog/pad_driver.sv ----
// registered output stage for the debug pads
module pad_driver #(
   parameter int unsigned pads = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [pads-1:0] route_sel,
   input wire logic [pads-1:0] route_level,
   input wire logic [pads-1:0] normal_out,
   input wire logic [pads-1:0] normal_oe,
   output logic [pads-1:0] pad_out,
   output logic [pads-1:0] pad_oe
);

   typedef struct packed {
      logic [pads-1:0] out;
      logic [pads-1:0] oe;
   } pad_state_t;

   pad_state_t state;
   pad_state_t next_state;

   always_comb
   begin
      next_state = state;
      for (int i = 0; i < pads; i++)
      begin
         if (route_sel[i])
         begin
            next_state.out[i] = route_level[i];
            next_state.oe[i] = 1'b1;
         end
         else
         begin
            next_state.out[i] = normal_out[i];
            next_state.oe[i] = normal_oe[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign pad_out = state.out;
   assign pad_oe = state.oe;

endmodule

// ---- verilog/testbus_pad_router.sv ----
// test bus pad router with apb configuration registers
module testbus_pad_router #(
   parameter int unsigned tb_w = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [testbus_pkg::addr_w-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [tb_w-1:0] test_bus,
   input wire logic clk_13m,
   input wire logic dac_one_level,
   input wire logic dac_two_level,
   input wire logic [3:0] normal_out,
   input wire logic [3:0] normal_oe,
   output logic [3:0] pad_out,
   output logic [3:0] pad_oe,
   output logic [7:0] debug_group_select,
   output logic [7:0] dac_one_source_select,
   output logic [7:0] dac_two_source_select
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic enable;
      logic [7:0] test_output_mode;
      logic [7:0] group;
      logic [7:0] zero_to_one;
      logic [7:0] map_count;
      logic [31:0] entries;
      logic [7:0] dac_one;
      logic [7:0] dac_two;
      logic [31:0] rdata;
   } router_state_t;

   router_state_t state;
   router_state_t next_state;

   logic [tb_w-1:0] bus_eff;
   logic [3:0] hit [testbus_pkg::num_entries];
   logic [testbus_pkg::num_entries-1:0] lvl;
   logic [3:0] route_sel;
   logic [3:0] route_level;
   logic analog_on;
   logic digital_on;
   logic setup;
   logic access;
   logic mapped;

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      unmapped = 4'b0000,
      enable_sel = 4'b0001,
      mode_sel = 4'b0010,
      group_sel = 4'b0011,
      zero_to_one_sel = 4'b0100,
      count_sel = 4'b0101,
      entries_sel = 4'b0110,
      dac_one_sel = 4'b0111,
      dac_two_sel = 4'b1000,
      status_sel = 4'b1001
   } reg_sel_t;

   reg_sel_t sel;

   // address decode shared by the error, read and write paths
   function automatic reg_sel_t decode_reg(
      input logic [testbus_pkg::addr_w-1:0] addr
   );
      unique case (addr)
         testbus_pkg::reg_addr(testbus_pkg::idx_enable):
            decode_reg = enable_sel;
         testbus_pkg::reg_addr(testbus_pkg::idx_mode):
            decode_reg = mode_sel;
         testbus_pkg::reg_addr(testbus_pkg::idx_group):
            decode_reg = group_sel;
         testbus_pkg::reg_addr(testbus_pkg::idx_zero_to_one):
            decode_reg = zero_to_one_sel;
         testbus_pkg::reg_addr(testbus_pkg::idx_map_count):
            decode_reg = count_sel;
         testbus_pkg::reg_addr(testbus_pkg::idx_map_entries):
            decode_reg = entries_sel;
         testbus_pkg::reg_addr(testbus_pkg::idx_dac_one):
            decode_reg = dac_one_sel;
         testbus_pkg::reg_addr(testbus_pkg::idx_dac_two):
            decode_reg = dac_two_sel;
         testbus_pkg::reg_addr(testbus_pkg::idx_pad_status):
            decode_reg = status_sel;
         default:
            decode_reg = unmapped;
      endcase
   endfunction

   // an entry is live while its index is below the configured count
   function automatic logic entry_live(
      input int unsigned idx,
      input logic [7:0] count
   );
      entry_live = 8'(idx) < count;
   endfunction

   // ----------------------------------------------------------------
   // test bus conditioning and entry decode
   // ----------------------------------------------------------------
   always_comb
   begin
      bus_eff = test_bus;
      if (state.zero_to_one == testbus_pkg::map_zero_onto_one)
      begin
         bus_eff[1] = test_bus[0];
      end
   end

   assign analog_on = state.enable &&
      state.test_output_mode == testbus_pkg::mode_analog;
   assign digital_on = state.enable &&
      state.test_output_mode == testbus_pkg::mode_digital;

   generate
      for (genvar g = 0; g < testbus_pkg::num_entries; g++)
      begin : entry_dec
         map_entry_decoder #(
            .tb_w(tb_w)
         ) u_dec (
            .entry(state.entries[g*testbus_pkg::entry_w +:
               testbus_pkg::entry_w]),
            .active(digital_on &&
               entry_live(g, state.map_count)),
            .test_bus(bus_eff),
            .clk_13m(clk_13m),
            .pad_hit(hit[g]),
            .level(lvl[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // route selection, later entries win on a shared pad
   // ----------------------------------------------------------------
   always_comb
   begin
      route_sel = 4'h0;
      route_level = 4'h0;
      for (int e = 0; e < testbus_pkg::num_entries; e++)
      begin
         for (int p = 0; p < testbus_pkg::num_pads; p++)
         begin
            if (hit[e][p])
            begin
               route_sel[p] = 1'b1;
               route_level[p] = lvl[e];
            end
         end
      end
      if (analog_on)
      begin
         route_sel[testbus_pkg::pad_irq] = 1'b1;
         route_level[testbus_pkg::pad_irq] = dac_one_level;
         route_sel[testbus_pkg::pad_aux_two] = 1'b1;
         route_level[testbus_pkg::pad_aux_two] = dac_two_level;
      end
   end

   pad_driver #(
      .pads(testbus_pkg::num_pads)
   ) u_pads (
      .pclk(pclk),
      .presetn(presetn),
      .route_sel(route_sel),
      .route_level(route_level),
      .normal_out(normal_out),
      .normal_oe(normal_oe),
      .pad_out(pad_out),
      .pad_oe(pad_oe)
   );

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign sel = decode_reg(paddr);
   assign mapped = sel != unmapped;

   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   always_comb
   begin
      next_state = state;
      // read data is captured in the setup cycle
      if (setup)
      begin
         next_state.rdata = 32'h0000_0000;
         unique case (sel)
            enable_sel:
               next_state.rdata[testbus_pkg::enable_bit] = state.enable;
            mode_sel:
               next_state.rdata[7:0] = state.test_output_mode;
            group_sel:
               next_state.rdata[7:0] = state.group;
            zero_to_one_sel:
               next_state.rdata[7:0] = state.zero_to_one;
            count_sel:
               next_state.rdata[7:0] = state.map_count;
            entries_sel:
               next_state.rdata = state.entries;
            dac_one_sel:
               next_state.rdata[7:0] = state.dac_one;
            dac_two_sel:
               next_state.rdata[7:0] = state.dac_two;
            status_sel:
               next_state.rdata[7:0] = {pad_oe, pad_out};
            default:
               next_state.rdata = 32'h0000_0000;
         endcase
      end
      // byte registers take lane zero only
      if (access && pwrite && pstrb[0])
      begin
         unique case (sel)
            enable_sel:
               next_state.enable = pwdata[testbus_pkg::enable_bit];
            mode_sel:
               next_state.test_output_mode = pwdata[7:0];
            group_sel:
               next_state.group = pwdata[7:0];
            zero_to_one_sel:
               next_state.zero_to_one = pwdata[7:0];
            count_sel:
               next_state.map_count = pwdata[7:0];
            dac_one_sel:
               next_state.dac_one = pwdata[7:0];
            dac_two_sel:
               next_state.dac_two = pwdata[7:0];
            default:
               next_state.rdata = next_state.rdata;
         endcase
      end
      if (access && pwrite && sel == entries_sel)
      begin
         for (int b = 0; b < testbus_pkg::num_entries; b++)
         begin
            if (pstrb[b])
            begin
               next_state.entries[b*testbus_pkg::entry_w +:
                  testbus_pkg::entry_w] =
                  pwdata[b*testbus_pkg::entry_w +: testbus_pkg::entry_w];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state.enable <= 1'b0;
         state.test_output_mode <= testbus_pkg::rst_byte;
         state.group <= testbus_pkg::rst_byte;
         state.zero_to_one <= testbus_pkg::map_zero_onto_one;
         state.map_count <= testbus_pkg::rst_byte;
         state.entries <= testbus_pkg::rst_word;
         state.dac_one <= testbus_pkg::rst_byte;
         state.dac_two <= testbus_pkg::rst_byte;
         state.rdata <= testbus_pkg::rst_word;
      end
      else
      begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign prdata = state.rdata;
   assign debug_group_select = state.group;
   assign dac_one_source_select = state.dac_one;
   assign dac_two_source_select = state.dac_two;

endmodule

// ---- dv/pad_probe.sv ----
// probe model of the test equipment watching the debug pads
module pad_probe (
   input wire logic pclk,
   input wire logic [3:0] pad_out,
   input wire logic [3:0] pad_oe,
   output logic [3:0] pin_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] last = 4'h0;
   // an undriven pin shows the inverse of its last level
   assign pin_level = (pad_oe & pad_out) | (~pad_oe & ~last);
   always_ff @(posedge pclk) last <= pin_level;
endmodule

// ---- dv/testbus_pad_router_sva.sv ----
// assertions on the ports of the test bus pad router
module testbus_pad_router_sva #(
   parameter int unsigned tb_w = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [testbus_pkg::addr_w-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic dac_one_level,
   input wire logic dac_two_level,
   input wire logic [3:0] normal_out,
   input wire logic [3:0] normal_oe,
   input wire logic [3:0] pad_out,
   input wire logic [3:0] pad_oe,
   input wire logic [7:0] debug_group_select,
   input wire logic [7:0] dac_one_source_select
);
   logic acc;
   logic wr;
   logic mapped;
   logic en_q;
   logic [7:0] mode_q;
   assign acc = psel && penable;
   assign wr = acc && pwrite && pstrb[0];
   assign mapped = paddr == 12'h05c || paddr == 12'h3e0 ||
      (paddr >= 12'h3c0 && paddr <= 12'h3d8 && paddr[1:0] == 2'b00);
   // shadow of enable and mode
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         en_q <= 1'b0;
         mode_q <= 8'h00;
      end
      else if (wr)
      begin
         if (paddr == 12'h05c) en_q <= pwdata[0];
         if (paddr == 12'h3c0) mode_q <= pwdata[7:0];
      end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_pads_normal: assert property (
      !en_q || !(mode_q inside {8'h01, 8'h02})
      |=> pad_out == $past(normal_out) && pad_oe == $past(normal_oe))
      else $error("pads left normal function");
   a_irq_dac_one: assert property (en_q && mode_q == 8'h01
      |=> pad_out[0] == $past(dac_one_level))
      else $error("irq pad not from first dac");
   a_aux_dac_two: assert property (en_q && mode_q == 8'h01
      |=> pad_out[1] == $past(dac_two_level))
      else $error("aux two pad not from second dac");
   a_zero_wait: assert property (psel && !penable |=> pready)
      else $error("access cycle not ready");
   a_err_unmapped: assert property (acc |-> pslverr == !mapped)
      else $error("slave error wrong");
   a_read_zero: assert property (acc && !pwrite && !mapped |-> prdata == 0)
      else $error("unmapped read not zero");
   a_group_write: assert property (wr && paddr == 12'h3c4
      |=> debug_group_select == $past(pwdata[7:0]))
      else $error("group select not written");
   a_dac_write: assert property (wr && paddr == 12'h3d4
      |=> dac_one_source_select == $past(pwdata[7:0]))
      else $error("dac one select not written");
   a_status_read: assert property (acc && !pwrite && paddr == 12'h3e0
      |-> prdata[7:0] == {$past(pad_oe), $past(pad_out)})
      else $error("pad status read wrong");
endmodule

bind testbus_pad_router testbus_pad_router_sva #(.tb_w(tb_w)) sva_i (.pclk,
   .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
   .pready, .pslverr, .dac_one_level, .dac_two_level, .normal_out,
   .normal_oe, .pad_out, .pad_oe, .debug_group_select, .dac_one_source_select);

// ---- dv/test_testbus_pad_router.sv ----
// self-checking bench for the test bus pad router
module test_testbus_pad_router;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, clk_13m;
   logic dac_one_level, dac_two_level;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb, normal_out, normal_oe, pad_out, pad_oe, pin_level;
   logic [7:0] test_bus, debug_group_select, dac_one_sel, dac_two_sel;
   int miscompares, comparisons;
   testbus_pad_router testbus_pad_router_i (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .test_bus,
      .clk_13m, .dac_one_level, .dac_two_level, .normal_out, .normal_oe,
      .pad_out, .pad_oe, .debug_group_select,
      .dac_one_source_select(dac_one_sel), .dac_two_source_select(dac_two_sel));
   pad_probe pad_probe_i (.pclk, .pad_out, .pad_oe, .pin_level);
   task automatic chk(input string what, input logic [31:0] exp, got);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic xfer(input logic [11:0] a, input logic w,
      input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      xfer(a, 1'b1, d, 4'hf, r, e);
   endtask
   task automatic cfg(input logic [7:0] m, c, input logic [31:0] ent);
      wr(12'h05c, 32'h1);
      wr(12'h3c0, {24'h0, m});
      wr(12'h3cc, {24'h0, c});
      wr(12'h3d0, ent);
   endtask
   task automatic pads(input logic [3:0] mask, exp);
      repeat (2) @(posedge pclk);
      #1;
      chk("pad_out", {28'h0, exp}, {28'h0, pad_out & mask});
      chk("pin level", {28'h0, exp & mask & pad_oe},
         {28'h0, pin_level & mask & pad_oe});
   endtask
   task automatic t_regs;
      logic [11:0] a [7] = '{12'h3c0, 12'h3c4, 12'h3c8, 12'h3cc, 12'h3d0,
         12'h3d4, 12'h3d8};
      logic [31:0] r;
      logic e;
      foreach (a[i])
      begin
         xfer(a[i], 1'b0, 32'h0, 4'h0, r, e);
         chk("reset value", 32'h0, r);
         wr(a[i], 32'ha5c3e187);
         xfer(a[i], 1'b0, 32'h0, 4'h0, r, e);
         chk("read back", a[i] == 12'h3d0 ? 32'ha5c3e187 : 32'h87, r);
      end
      chk("group out", 32'h87, {24'h0, debug_group_select});
      chk("dac two out", 32'h87, {24'h0, dac_two_sel});
      chk("dac one out", 32'h87, {24'h0, dac_one_sel});
      xfer(12'h05c, 1'b0, 32'h0, 4'h0, r, e);
      chk("enable reset", 32'h0, r);
      wr(12'h05c, 32'h3);
      xfer(12'h05c, 1'b0, 32'h0, 4'h0, r, e);
      chk("enable read", 32'h1, r);
      xfer(12'h3d4, 1'b1, 32'h11, 4'h0, r, e);
      xfer(12'h3d4, 1'b0, 32'h0, 4'h0, r, e);
      chk("no strobe write", 32'h87, r);
      xfer(12'h3f0, 1'b0, 32'h0, 4'h0, r, e);
      chk("unmapped error", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, r);
      wr(12'h3c8, 32'h0);
   endtask
   task automatic t_digital;
      logic [31:0] r;
      logic e;
      normal_out <= 4'h0;
      test_bus <= 8'h28;
      clk_13m <= 1'b1;
      cfg(8'h02, 8'h04, 32'h38271503);
      pads(4'hf, 4'hb);
      xfer(12'h3e0, 1'b0, 32'h0, 4'h0, r, e);
      chk("pad status", 32'hb, r & 32'hf);
      test_bus <= 8'h80;
      pads(4'hf, 4'hc);
      clk_13m <= 1'b0;
      pads(4'hf, 4'h4);
      test_bus <= 8'h28;
      cfg(8'h02, 8'h02, 32'h38271503);
      pads(4'hf, 4'h3);
      normal_out <= 4'ha;
      cfg(8'h02, 8'h00, 32'h38271503);
      pads(4'hf, 4'ha);
   endtask
   task automatic t_modes;
      normal_out <= 4'h6;
      test_bus <= 8'h08;
      cfg(8'h03, 8'h01, 32'h03);
      pads(4'hf, 4'h6);
      cfg(8'h02, 8'h01, 32'h03);
      pads(4'hf, 4'h7);
      wr(12'h05c, 32'h0);
      pads(4'hf, 4'h6);
      normal_out <= 4'h1;
      cfg(8'h02, 8'h02, 32'h1340);
      pads(4'hf, 4'h3);
      normal_out <= 4'h0;
      test_bus <= 8'h01;
      cfg(8'h02, 8'h01, 32'h01);
      pads(4'hf, 4'h1);
      wr(12'h3c8, 32'h1);
      pads(4'hf, 4'h0);
   endtask
   task automatic t_analog;
      normal_out <= 4'hc;
      dac_one_level <= 1'b1;
      cfg(8'h01, 8'h04, 32'h38271503);
      pads(4'hf, 4'hd);
      dac_one_level <= 1'b0;
      dac_two_level <= 1'b1;
      pads(4'hf, 4'he);
   endtask
   task automatic end_of_test;
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial
   begin
      #100us;
      miscompares++;
      end_of_test;
   end
   initial
   begin
      {presetn, psel, penable, pwrite, clk_13m} = 5'h0;
      {dac_one_level, dac_two_level} = 2'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      pstrb = 4'h0;
      test_bus = 8'h0;
      normal_out = 4'h0;
      normal_oe = 4'h5;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_digital;
      t_modes;
      t_analog;
      end_of_test;
   end
endmodule
